// File: include/pebs_pkg.sv
// package: register map, field layout and types for the edge blank source block
`default_nettype none
package pebs_pkg;
	localparam logic [11:0] PEBS_RISE_SRC_OFF = 12'h000;
	localparam logic [11:0] PEBS_FALL_SRC_OFF = 12'h004;
	localparam logic [11:0] PEBS_MODE_OFF = 12'h008;
	localparam logic [11:0] PEBS_STATUS_OFF = 12'h00c;
	localparam int PEBS_PIN_BIT = 7;
	localparam int PEBS_CMP3_BIT = 3;
	localparam int PEBS_CMP2_BIT = 2;
	localparam int PEBS_CMP1_BIT = 1;
	localparam logic [7:0] PEBS_SRC_IMPL_MASK = 8'h8e;
	localparam logic [7:0] PEBS_SRC_RESET = 8'h00;
	localparam int PEBS_RISE_MODE_LSB = 0;
	localparam int PEBS_FALL_MODE_LSB = 4;
	localparam logic [7:0] PEBS_MODE_IMPL_MASK = 8'h33;
	localparam logic [7:0] PEBS_MODE_RESET = 8'h00;
	localparam logic [1:0] PEBS_MODE_NONE = 2'h0;
	localparam logic [1:0] PEBS_MODE_IMMEDIATE = 2'h1;
	localparam logic [7:0] PEBS_DURATION_RESET = 8'h00;
	localparam logic [31:0] PEBS_READ_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic pin;
		logic cmp3;
		logic cmp2;
		logic cmp1;
	} pebs_src_t;

	typedef enum logic [1:0] {
		PEBS_IDLE,
		PEBS_BLANK_RISE,
		PEBS_BLANK_FALL
	} pebs_state_t;
endpackage
`default_nettype wire

// File: src/pebs_blank_timer.sv
// module: blanking interval timer started at output edges
`default_nettype none
module pebs_blank_timer
	import pebs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic rise_edge_i,
	input wire logic fall_edge_i,
	input wire logic [1:0] rise_blank_mode_i,
	input wire logic [1:0] fall_blank_mode_i,
	input wire logic [7:0] duration_i,
	output pebs_state_t state_o
);
	pebs_state_t state_reg;
	logic [7:0] count_reg;

	// a new edge restarts the interval; falling wins if both edges coincide
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			state_reg <= PEBS_IDLE;
			count_reg <= 8'h00;
		end else if (fall_edge_i && fall_blank_mode_i == PEBS_MODE_IMMEDIATE
			&& duration_i != 8'h00) begin
			state_reg <= PEBS_BLANK_FALL;
			count_reg <= duration_i;
		end else if (rise_edge_i && rise_blank_mode_i == PEBS_MODE_IMMEDIATE
			&& duration_i != 8'h00) begin
			state_reg <= PEBS_BLANK_RISE;
			count_reg <= duration_i;
		end else begin
			case (state_reg)
				PEBS_IDLE: begin
					count_reg <= 8'h00;
				end
				PEBS_BLANK_RISE, PEBS_BLANK_FALL: begin
					if (count_reg <= 8'h01) begin
						state_reg <= PEBS_IDLE;
						count_reg <= 8'h00;
					end else begin
						count_reg <= count_reg - 8'h01;
					end
				end
				default: begin
					state_reg <= PEBS_IDLE;
					count_reg <= 8'h00;
				end
			endcase
		end
	end

	assign state_o = state_reg;

	a_blank_ends: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(state_reg != PEBS_IDLE && count_reg == 8'h01 && !rise_edge_i && !fall_edge_i)
		|=> state_reg == PEBS_IDLE)
		else $error("blanking interval did not end");
	a_rise_start: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(rise_edge_i && !fall_edge_i && rise_blank_mode_i == PEBS_MODE_IMMEDIATE
		&& duration_i != 8'h00) |=> state_reg == PEBS_BLANK_RISE)
		else $error("rising blank did not start");
	a_fall_start: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(fall_edge_i && fall_blank_mode_i == PEBS_MODE_IMMEDIATE && duration_i != 8'h00)
		|=> state_reg == PEBS_BLANK_FALL)
		else $error("falling blank did not start");
endmodule
`default_nettype wire

// File: src/pebs_edge_blank.sv
// module: edge blank source select with apb registers and event gating
//
// The address map and register access over APB were decided locally.
`default_nettype none
module pebs_edge_blank
	import pebs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rise_edge_i,
	input wire logic fall_edge_i,
	input wire pebs_src_t event_raw_i,
	output pebs_src_t event_o,
	output logic blank_active_o
);
	logic [7:0] rise_src_reg;
	logic [7:0] fall_src_reg;
	logic [7:0] mode_reg;
	logic [7:0] duration_reg;
	logic wr_en;
	logic rd_en;
	logic mapped;
	pebs_state_t blank_state;
	logic [7:0] active_mask;
	pebs_src_t event_next;
	logic [3:0] rise_mask_vec;
	logic [3:0] fall_mask_vec;

	function automatic pebs_src_t src_of(input logic [7:0] r);
		src_of.pin = r[PEBS_PIN_BIT];
		src_of.cmp3 = r[PEBS_CMP3_BIT];
		src_of.cmp2 = r[PEBS_CMP2_BIT];
		src_of.cmp1 = r[PEBS_CMP1_BIT];
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == PEBS_RISE_SRC_OFF) || (a == PEBS_FALL_SRC_OFF)
			|| (a == PEBS_MODE_OFF) || (a == PEBS_STATUS_OFF);
	endfunction

	// zero wait states; unmapped addresses answer with pslverr
	assign mapped = is_mapped(paddr_i);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0] && mapped;
	assign rd_en = psel_i && !penable_i && !pwrite_i;

	// unimplemented bits never store, so they read back zero
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rise_src_reg <= PEBS_SRC_RESET;
		end else if (wr_en && paddr_i == PEBS_RISE_SRC_OFF) begin
			rise_src_reg <= pwdata_i[7:0] & PEBS_SRC_IMPL_MASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			fall_src_reg <= PEBS_SRC_RESET;
		end else if (wr_en && paddr_i == PEBS_FALL_SRC_OFF) begin
			fall_src_reg <= pwdata_i[7:0] & PEBS_SRC_IMPL_MASK;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			mode_reg <= PEBS_MODE_RESET;
			duration_reg <= PEBS_DURATION_RESET;
		end else if (wr_en && paddr_i == PEBS_MODE_OFF) begin
			mode_reg <= pwdata_i[7:0] & PEBS_MODE_IMPL_MASK;
			duration_reg <= pwdata_i[15:8];
		end
	end

	// read data registered in setup, valid in the access phase
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			prdata_o <= PEBS_READ_ZERO;
		end else if (rd_en) begin
			case (paddr_i)
				PEBS_RISE_SRC_OFF: prdata_o <= {24'h000000, rise_src_reg};
				PEBS_FALL_SRC_OFF: prdata_o <= {24'h000000, fall_src_reg};
				PEBS_MODE_OFF: prdata_o <= {16'h0000, duration_reg, mode_reg};
				PEBS_STATUS_OFF: prdata_o <= {30'h00000000, blank_state};
				default: prdata_o <= PEBS_READ_ZERO;
			endcase
		end
	end

	pebs_blank_timer u_timer (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.rise_edge_i(rise_edge_i),
		.fall_edge_i(fall_edge_i),
		.rise_blank_mode_i(mode_reg[PEBS_RISE_MODE_LSB +: 2]),
		.fall_blank_mode_i(mode_reg[PEBS_FALL_MODE_LSB +: 2]),
		.duration_i(duration_reg),
		.state_o(blank_state)
	);

	always_comb begin
		case (blank_state)
			PEBS_BLANK_RISE: active_mask = rise_src_reg;
			PEBS_BLANK_FALL: active_mask = fall_src_reg;
			default: active_mask = 8'h00;
		endcase
	end

	// dropped, not held: a blanked event is simply gone
	assign event_next = event_raw_i & ~src_of(active_mask);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			event_o <= '0;
			blank_active_o <= 1'b0;
		end else begin
			event_o <= event_next;
			blank_active_o <= (blank_state != PEBS_IDLE);
		end
	end

	// flat views so the per-source checks can index one bit
	assign rise_mask_vec = src_of(rise_src_reg);
	assign fall_mask_vec = src_of(fall_src_reg);

	// one set of checks for each bit of the event struct
	for (genvar g = 0; g < 4; g++) begin : g_src_chk
		a_rise_blanked: assert property (@(posedge clk_sys_i) disable iff (srst_i)
			(blank_state == PEBS_BLANK_RISE && rise_mask_vec[g]) |=> !event_o[g])
			else $error("rising-blanked source event passed");
		a_fall_blanked: assert property (@(posedge clk_sys_i) disable iff (srst_i)
			(blank_state == PEBS_BLANK_FALL && fall_mask_vec[g]) |=> !event_o[g])
			else $error("falling-blanked source event passed");
		a_rise_open: assert property (@(posedge clk_sys_i) disable iff (srst_i)
			(blank_state == PEBS_BLANK_RISE && !rise_mask_vec[g])
			|=> event_o[g] == $past(event_raw_i[g]))
			else $error("unmasked source lost in rising blank");
		a_fall_open: assert property (@(posedge clk_sys_i) disable iff (srst_i)
			(blank_state == PEBS_BLANK_FALL && !fall_mask_vec[g])
			|=> event_o[g] == $past(event_raw_i[g]))
			else $error("unmasked source lost in falling blank");
	end

	a_src_pin_masked: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(blank_state == PEBS_BLANK_FALL && fall_src_reg[PEBS_PIN_BIT]) |=> !event_o.pin)
		else $error("falling-blanked pin event passed");
	a_src_cmp_masked: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(blank_state == PEBS_BLANK_RISE && rise_src_reg[PEBS_CMP1_BIT]) |=> !event_o.cmp1)
		else $error("rising-blanked comparator event passed");
	a_idle_passes: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(blank_state == PEBS_IDLE) |=> event_o == $past(event_raw_i))
		else $error("event lost outside blanking");
	a_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		((rise_src_reg | fall_src_reg) & ~PEBS_SRC_IMPL_MASK) == 8'h00)
		else $error("unimplemented source bit set");
	a_reset_clears: assert property (@(posedge clk_sys_i)
		srst_i |=> rise_src_reg == 8'h00 && fall_src_reg == 8'h00)
		else $error("mask bits not cleared by reset");
	a_reset_outputs: assert property (@(posedge clk_sys_i)
		srst_i |=> event_o == '0 && !blank_active_o && prdata_o == PEBS_READ_ZERO)
		else $error("outputs not cleared by reset");
	a_write_stores: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(wr_en && paddr_i == PEBS_RISE_SRC_OFF)
		|=> rise_src_reg == ($past(pwdata_i[7:0]) & PEBS_SRC_IMPL_MASK))
		else $error("rising source write lost");
	a_fall_stores: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(wr_en && paddr_i == PEBS_FALL_SRC_OFF)
		|=> fall_src_reg == ($past(pwdata_i[7:0]) & PEBS_SRC_IMPL_MASK))
		else $error("falling source write lost");
	a_strb_ignored: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(psel_i && penable_i && pwrite_i && !pstrb_i[0])
		|=> $stable(rise_src_reg) && $stable(fall_src_reg))
		else $error("write without byte strobe stored");
	a_read_rise: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(rd_en && paddr_i == PEBS_RISE_SRC_OFF)
		|=> prdata_o == {24'h000000, $past(rise_src_reg)})
		else $error("rising source read wrong");
	a_read_fall: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(rd_en && paddr_i == PEBS_FALL_SRC_OFF)
		|=> prdata_o == {24'h000000, $past(fall_src_reg)})
		else $error("falling source read wrong");
	a_mode_read: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(rd_en && paddr_i == PEBS_MODE_OFF)
		|=> prdata_o[7:0] == $past(mode_reg))
		else $error("mode read wrong");
	a_status_read: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(rd_en && paddr_i == PEBS_STATUS_OFF)
		|=> prdata_o[1:0] == $past(blank_state))
		else $error("status read wrong");
	a_mode_none: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(mode_reg == PEBS_MODE_RESET && blank_state == PEBS_IDLE) |=> blank_state == PEBS_IDLE)
		else $error("blanking began with both modes off");
	a_reserved_rise: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(rise_edge_i && !fall_edge_i && blank_state == PEBS_IDLE
		&& mode_reg[PEBS_RISE_MODE_LSB +: 2] != PEBS_MODE_IMMEDIATE) |=> blank_state == PEBS_IDLE)
		else $error("rising blank began outside immediate mode");
	a_reserved_fall: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		(fall_edge_i && !rise_edge_i && blank_state == PEBS_IDLE
		&& mode_reg[PEBS_FALL_MODE_LSB +: 2] != PEBS_MODE_IMMEDIATE) |=> blank_state == PEBS_IDLE)
		else $error("falling blank began outside immediate mode");
	a_zero_duration: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		((rise_edge_i || fall_edge_i) && duration_reg == 8'h00
		&& blank_state == PEBS_IDLE) |=> blank_state == PEBS_IDLE)
		else $error("blanking began with zero duration");
	a_active_follows: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		1'b1 |=> blank_active_o == ($past(blank_state) != PEBS_IDLE))
		else $error("blank active flag out of step");
endmodule
`default_nettype wire

// File: verification/pebs_src_model.sv
// source model: comparators and input pin raising events on request
`default_nettype none
module pebs_src_model
	import pebs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire pebs_src_t fire_i,
	output var pebs_src_t event_raw_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// registered, like a synchronised comparator output
	always_ff @(posedge clk_sys_i) begin
		event_raw_o <= fire_i;
	end
endmodule
`default_nettype wire

// File: verification/tb_pebs_edge_blank.sv
// testbench: apb registers and edge blanking of event sources
`default_nettype none
module tb_pebs_edge_blank;
	import pebs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [3:0] pstrb_i = 4'h0;
	logic rise_edge_i = 1'b0;
	logic fall_edge_i = 1'b0;
	pebs_src_t fire = 4'h0;
	pebs_src_t event_raw;
	pebs_src_t event_o;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	logic blank_active_o;
	logic [31:0] q;
	logic e;
	int n_errors = 0;
	int check_count = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	pebs_src_model src_u (.clk_sys_i(clk_sys_i), .fire_i(fire), .event_raw_o(event_raw));
	pebs_edge_blank dut_u (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.rise_edge_i(rise_edge_i), .fall_edge_i(fall_edge_i), .event_raw_i(event_raw),
		.event_o(event_o), .blank_active_o(blank_active_o));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		pstrb_i <= s;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic regs_zero();
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(i * 4), 32'h0, 4'h1);
			chk("reset value", q, 32'h0);
		end
	endtask
	// mode m on one edge, 8 cycles long; only code 01 may blank
	task automatic blank(input logic [1:0] m, input logic fall);
		logic [31:0] w;
		logic hit;
		w = 32'h0800 | (32'(m) << (fall ? 4 : 0));
		apb(1'b1, PEBS_MODE_OFF, w, 4'h1);
		apb(1'b0, PEBS_MODE_OFF, 32'h0, 4'h1);
		chk("mode word", q, w);
		@(posedge clk_sys_i);
		rise_edge_i <= !fall;
		fall_edge_i <= fall;
		@(posedge clk_sys_i);
		rise_edge_i <= 1'b0;
		fall_edge_i <= 1'b0;
		// blanking covers samples 1..8 after the edge, seen at the next negedge
		for (int k = 0; k < 12; k++) begin
			@(negedge clk_sys_i);
			hit = (m == PEBS_MODE_IMMEDIATE) && k >= 1 && k <= 8;
			chk("in blank", 32'(event_o), hit ? (fall ? 32'h1 : 32'h6) : 32'hf);
			chk("blank active", 32'(blank_active_o), 32'(hit));
		end
		repeat (3) @(negedge clk_sys_i);
		chk("after blank", 32'(event_o), 32'hf);
	endtask
	// one-cycle burst inside rising blank: masked sources must never show later
	task automatic drop_check();
		apb(1'b1, PEBS_MODE_OFF, 32'h0000_0801, 4'h1);
		@(posedge clk_sys_i);
		fire <= 4'h0;
		rise_edge_i <= 1'b1;
		@(posedge clk_sys_i);
		rise_edge_i <= 1'b0;
		fire <= 4'hf;
		@(posedge clk_sys_i);
		fire <= 4'h0;
		for (int k = 1; k < 13; k++) begin
			@(negedge clk_sys_i);
			chk("dropped", 32'(event_o), (k == 2) ? 32'h6 : 32'h0);
		end
	endtask
	task automatic final_report();
		if (n_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		n_errors++;
		final_report();
	end
	initial begin
		repeat (10) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		regs_zero();
		apb(1'b1, PEBS_RISE_SRC_OFF, 32'hffff_ffff, 4'h1);
		apb(1'b0, PEBS_RISE_SRC_OFF, 32'h0, 4'h1);
		chk("rise src", q, 32'h8e);
		apb(1'b1, PEBS_FALL_SRC_OFF, 32'hffff_ffff, 4'h1);
		apb(1'b1, PEBS_FALL_SRC_OFF, 32'h0, 4'h0);
		apb(1'b0, PEBS_FALL_SRC_OFF, 32'h0, 4'h1);
		chk("fall src", q, 32'h8e);
		apb(1'b0, 12'h010, 32'h0, 4'h1);
		chk("unmapped err", 32'(e), 32'h1);
		chk("unmapped data", q, 32'h0);
		apb(1'b1, PEBS_RISE_SRC_OFF, 32'h82, 4'h1);
		apb(1'b1, PEBS_FALL_SRC_OFF, 32'h8c, 4'h1);
		@(posedge clk_sys_i);
		fire <= 4'hf;
		for (int m = 0; m < 4; m++) begin
			blank(2'(m), 1'b0);
			blank(2'(m), 1'b1);
		end
		drop_check();
		// second reset in mid-run must clear everything again
		@(posedge clk_sys_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		srst_i <= 1'b0;
		regs_zero();
		final_report();
	end
endmodule
`default_nettype wire
